// *** hdl/gmss_core.sv ***
// Message buffering, busy hold-off and sweep synchronisation
// What this block does
// - Buffer up to 64 bytes of a message; execute nothing before its end byte arrives.
// - While executing a message, take in no further message bytes.
// - Hold not-ready-for-data asserted for the whole busy interval.
// - After execution, release hold-off and accept the next message.
// - Wait command stalls later commands of the message until sweep ends.
// - First single-sweep command selects single mode; later ones arm a sweep.
// - A sweep spans 10 divisions; waits on unarmed sweeps flag partial data.
// - Stored macros are all lost if backup supply drops.
// - Query output only starts after the preceding message has finished.
// - Talk-addressed with nothing pending sends one all-ones byte when idle.
// - With end-of-sweep request enabled, raise service request each sweep end.
`timescale 1ns/1ps
module gmss_core
	import gmss_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic msg_byte_valid,
	input wire logic [7:0] msg_byte,
	input wire logic msg_byte_last,
	output logic nrfd_q,
	output logic busy_q,
	output logic msg_overflow_q,
	output logic exec_cmd_valid_q,
	output logic [7:0] exec_cmd_q,
	input wire logic exec_done,
	input wire logic sweep_div_pin,
	input wire logic backup_ok_pin,
	output logic single_sweep_mode_q,
	output logic sweep_arm_q,
	output logic sweep_running_q,
	output logic partial_data_q,
	output logic srq_q,
	input wire logic serial_poll,
	output logic end_of_sweep_request_enable_q,
	output logic macro_valid_q,
	input wire logic macro_store_done,
	input wire logic talk_addressed,
	input wire logic talk_pending,
	output logic talk_enable_q,
	output logic talk_valid_q,
	output logic [7:0] talk_data_q
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic div_s1_q, div_s2_q, div_s3_q;
	logic bk_s1_q, bk_s2_q;

	always_ff @(posedge clk) begin
		div_s1_q <= sweep_div_pin;
		div_s2_q <= div_s1_q;
		div_s3_q <= div_s2_q;
		bk_s1_q <= backup_ok_pin;
		bk_s2_q <= bk_s1_q;
	end

	wire div_tick = div_s2_q & ~div_s3_q;

	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	gmss_state_t state_q, state_d;
	logic [BUF_AW:0] wr_cnt_q;
	logic [BUF_AW:0] rd_cnt_q;
	logic [7:0] rd_data;

	wire in_recv = (state_q == ST_RECV);
	wire take_byte = msg_byte_valid & in_recv & ~nrfd_q;
	wire buf_room = (wr_cnt_q != BUF_FULL);
	wire buf_write = take_byte & buf_room;
	wire msg_end = take_byte & msg_byte_last;
	wire all_read = (rd_cnt_q == wr_cnt_q);

	gmss_msg_buf u_buf (
		.clk(clk),
		.wr_en(buf_write),
		.wr_addr(wr_cnt_q[BUF_AW-1:0]),
		.wr_data(msg_byte),
		.rd_en(state_q == ST_FETCH),
		.rd_addr(rd_cnt_q[BUF_AW-1:0]),
		.rd_data_q(rd_data)
	);

	// ----------------------------------------
	// Sweep tracking
	// ----------------------------------------
	logic [3:0] div_cnt_q;
	logic armed_sweep_q;
	logic sweep_end_q;
	logic end_armed_q;

	wire dec_single = (state_q == ST_DECODE) & (rd_data == CMD_SINGLE_SWEEP_ARM);
	wire arm_now = dec_single & single_sweep_mode_q;
	wire last_div = (div_cnt_q == DIVS_PER_SWEEP - DIV_ONE);
	wire sweep_done = div_tick & sweep_running_q & last_div;

	always_ff @(posedge clk) begin
		if (rst) begin
			div_cnt_q <= DIV_ZERO;
			sweep_running_q <= 1'b1;
			armed_sweep_q <= 1'b0;
			sweep_end_q <= 1'b0;
			end_armed_q <= 1'b0;
		end else begin
			sweep_end_q <= sweep_done;
			// Keep the ending sweep's origin for the waiting executor
			if (sweep_done) begin
				end_armed_q <= armed_sweep_q;
			end
			if (arm_now) begin
				div_cnt_q <= DIV_ZERO;
				sweep_running_q <= 1'b1;
				armed_sweep_q <= 1'b1;
			end else if (sweep_done) begin
				div_cnt_q <= DIV_ZERO;
				sweep_running_q <= ~single_sweep_mode_q;
				armed_sweep_q <= 1'b0;
			end else if (div_tick & sweep_running_q) begin
				div_cnt_q <= div_cnt_q + DIV_ONE;
			end
		end
	end

	// ----------------------------------------
	// Executor state machine
	// ----------------------------------------
	wire is_wait = (rd_data == CMD_WAIT);
	wire is_local = is_wait | (rd_data == CMD_SINGLE_SWEEP_ARM) |
		(rd_data == CMD_END_REQ_ON) | (rd_data == CMD_END_REQ_OFF);
	wire sweep_idle = ~sweep_running_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RECV: begin
				if (msg_end) begin
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				state_d = all_read ? ST_RECV : ST_DECODE;
			end
			ST_DECODE: begin
				if (is_wait) begin
					state_d = sweep_idle ? ST_FETCH : ST_WAIT_SWEEP;
				end else if (is_local) begin
					state_d = ST_FETCH;
				end else begin
					state_d = ST_WAIT_DONE;
				end
			end
			ST_WAIT_DONE: begin
				if (exec_done) begin
					state_d = ST_FETCH;
				end
			end
			ST_WAIT_SWEEP: begin
				if (sweep_end_q) begin
					state_d = ST_FETCH;
				end
			end
			default: begin
				state_d = ST_RECV;
			end
		endcase
	end

	wire fetch_step = (state_q == ST_FETCH) & ~all_read;
	wire issue = (state_q == ST_DECODE) & ~is_local;
	wire exec_finish = (state_q == ST_FETCH) & all_read;
	wire busy_d = (state_d != ST_RECV);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_RECV;
			wr_cnt_q <= '0;
			rd_cnt_q <= '0;
			busy_q <= 1'b0;
			nrfd_q <= 1'b0;
			msg_overflow_q <= 1'b0;
			exec_cmd_valid_q <= 1'b0;
			exec_cmd_q <= 8'h00;
		end else begin
			state_q <= state_d;
			busy_q <= busy_d;
			nrfd_q <= busy_d | msg_end;
			exec_cmd_valid_q <= issue;
			if (issue) begin
				exec_cmd_q <= rd_data;
			end
			if (exec_finish) begin
				wr_cnt_q <= '0;
				rd_cnt_q <= '0;
			end else begin
				if (buf_write) begin
					wr_cnt_q <= wr_cnt_q + 1'b1;
				end
				if (fetch_step) begin
					rd_cnt_q <= rd_cnt_q + 1'b1;
				end
			end
			if (take_byte & ~buf_room) begin
				msg_overflow_q <= 1'b1;
			end else if (msg_byte_valid & in_recv & wr_cnt_q == '0) begin
				msg_overflow_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Sweep mode, request and data quality flags
	// ----------------------------------------
	wire wait_release = (state_q == ST_WAIT_SWEEP) & sweep_end_q;
	wire wait_now_idle = (state_q == ST_DECODE) & is_wait & sweep_idle;
	wire end_req_on = (state_q == ST_DECODE) & (rd_data == CMD_END_REQ_ON);
	wire end_req_off = (state_q == ST_DECODE) & (rd_data == CMD_END_REQ_OFF);

	always_ff @(posedge clk) begin
		if (rst) begin
			single_sweep_mode_q <= 1'b0;
			sweep_arm_q <= 1'b0;
			partial_data_q <= 1'b0;
			srq_q <= 1'b0;
			end_of_sweep_request_enable_q <= 1'b0;
		end else begin
			sweep_arm_q <= arm_now;
			if (dec_single) begin
				single_sweep_mode_q <= 1'b1;
			end
			if (wait_release) begin
				partial_data_q <= ~end_armed_q;
			end else if (wait_now_idle) begin
				partial_data_q <= 1'b0;
			end
			if (end_req_on) begin
				end_of_sweep_request_enable_q <= 1'b1;
			end else if (end_req_off) begin
				end_of_sweep_request_enable_q <= 1'b0;
			end
			// Set wins over the poll clear
			if (sweep_done & end_of_sweep_request_enable_q) begin
				srq_q <= 1'b1;
			end else if (serial_poll) begin
				srq_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Talk side and macro store validity
	// ----------------------------------------
	logic idle_byte_sent_q;

	wire idle_talk = talk_addressed & ~talk_pending & ~busy_q & ~idle_byte_sent_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			talk_enable_q <= 1'b0;
			talk_valid_q <= 1'b0;
			talk_data_q <= 8'h00;
			idle_byte_sent_q <= 1'b0;
			macro_valid_q <= 1'b0;
		end else begin
			talk_enable_q <= talk_addressed & ~busy_d;
			talk_valid_q <= idle_talk;
			if (idle_talk) begin
				talk_data_q <= IDLE_TALK_BYTE;
			end
			if (~talk_addressed) begin
				idle_byte_sent_q <= 1'b0;
			end else if (idle_talk) begin
				idle_byte_sent_q <= 1'b1;
			end
			// Loss of backup wipes every stored macro
			if (~bk_s2_q) begin
				macro_valid_q <= 1'b0;
			end else if (macro_store_done) begin
				macro_valid_q <= 1'b1;
			end
		end
	end

endmodule

// *** hdl/gmss_msg_buf.sv ***
// Message byte store with registered read data
`timescale 1ns/1ps
module gmss_msg_buf
	import gmss_pkg::*;
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [BUF_AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [BUF_AW-1:0] rd_addr,
	output logic [7:0] rd_data_q
);

	logic [7:0] mem [BUF_DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data_q <= mem[rd_addr];
		end
	end

endmodule

// *** hdl/gmss_pkg.sv ***
// Constants for the message buffering and sweep synchronisation block
package gmss_pkg;

	// ----------------------------------------
	// Message buffer
	// ----------------------------------------
	localparam int BUF_AW = 6;
	localparam int BUF_DEPTH = 1 << BUF_AW;
	localparam logic [BUF_AW:0] BUF_FULL = 7'h40;

	// ----------------------------------------
	// Command tokens from the parser
	// ----------------------------------------
	localparam logic [7:0] CMD_WAIT = 8'h01;
	localparam logic [7:0] CMD_SINGLE_SWEEP_ARM = 8'h02;
	localparam logic [7:0] CMD_END_REQ_ON = 8'h03;
	localparam logic [7:0] CMD_END_REQ_OFF = 8'h04;

	// ----------------------------------------
	// Sweep and talk constants
	// ----------------------------------------
	localparam logic [3:0] DIVS_PER_SWEEP = 4'hA;
	localparam logic [3:0] DIV_ZERO = 4'h0;
	localparam logic [3:0] DIV_ONE = 4'h1;
	localparam logic [7:0] IDLE_TALK_BYTE = 8'hFF;

	// ----------------------------------------
	// Executor states, Gray from ST_RECV to ST_WAIT_DONE; ST_WAIT_DONE back to ST_FETCH flips two bits
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_RECV = 3'h0,
		ST_FETCH = 3'h1,
		ST_DECODE = 3'h3,
		ST_WAIT_DONE = 3'h2,
		ST_WAIT_SWEEP = 3'h6
	} gmss_state_t;

endpackage

// *** sim/gmss_core_props.sv ***
// Port assertions for the message and sweep block
`timescale 1ns/1ps
module gmss_core_props
	import gmss_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic msg_byte_valid,
	input wire logic msg_byte_last,
	input wire logic nrfd_q,
	input wire logic busy_q,
	input wire logic exec_cmd_valid_q,
	input wire logic single_sweep_mode_q,
	input wire logic sweep_arm_q,
	input wire logic srq_q,
	input wire logic end_of_sweep_request_enable_q,
	input wire logic talk_enable_q,
	input wire logic talk_valid_q,
	input wire logic [7:0] talk_data_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_end; msg_byte_valid && msg_byte_last && !nrfd_q |=> nrfd_q; endproperty
	a_end: assert property (p_end) else $error("no hold-off");
	property p_run; exec_cmd_valid_q |-> busy_q && nrfd_q; endproperty
	a_run: assert property (p_run) else $error("issue when idle");
	property p_hold; busy_q |-> nrfd_q; endproperty
	a_hold: assert property (p_hold) else $error("busy, no hold");
	property p_free; $fell(busy_q) |-> !nrfd_q; endproperty
	a_free: assert property (p_free) else $error("hold kept");
	property p_arm; sweep_arm_q |-> $past(single_sweep_mode_q); endproperty
	a_arm: assert property (p_arm) else $error("arm in free run");
	property p_srq; $rose(srq_q) |-> $past(end_of_sweep_request_enable_q); endproperty
	a_srq: assert property (p_srq) else $error("request not enabled");
	property p_idle; talk_valid_q |-> talk_data_q == IDLE_TALK_BYTE && !$past(busy_q); endproperty
	a_idle: assert property (p_idle) else $error("bad idle byte");
	property p_talk; talk_enable_q |-> !busy_q && !nrfd_q; endproperty
	a_talk: assert property (p_talk) else $error("talk while busy");
endmodule
bind gmss_core gmss_core_props u_props (
	.clk(clk),
	.rst(rst),
	.msg_byte_valid(msg_byte_valid),
	.msg_byte_last(msg_byte_last),
	.nrfd_q(nrfd_q),
	.busy_q(busy_q),
	.exec_cmd_valid_q(exec_cmd_valid_q),
	.single_sweep_mode_q(single_sweep_mode_q),
	.sweep_arm_q(sweep_arm_q),
	.srq_q(srq_q),
	.end_of_sweep_request_enable_q(end_of_sweep_request_enable_q),
	.talk_enable_q(talk_enable_q),
	.talk_valid_q(talk_valid_q),
	.talk_data_q(talk_data_q)
);

// *** sim/gmss_inst_model.sv ***
// Instrument side: command completion and sweep divisions
`timescale 1ns/1ps
module gmss_inst_model #(parameter int DLY = 8) (
	input wire logic clk,
	input wire logic exec_cmd_valid_q,
	input wire logic sweep_arm_q,
	input wire logic sweep_running_q,
	output logic exec_done = 1'b0,
	output logic sweep_div_pin = 1'b0,
	output int div_cnt = 0
);
	int wait_cnt = 0;
	int ph = 0;
	always @(posedge clk) begin
		exec_done <= (wait_cnt == 1);
		if (exec_cmd_valid_q)
			wait_cnt <= DLY;
		else if (wait_cnt != 0)
			wait_cnt <= wait_cnt - 1;
		ph <= (ph == 7) ? 0 : ph + 1;
		// Pin stands still once the sweep is over
		if (ph == 7 && sweep_running_q)
			sweep_div_pin <= ~sweep_div_pin;
		if (sweep_arm_q)
			div_cnt <= 0;
		else if (ph == 7 && sweep_running_q && !sweep_div_pin)
			div_cnt <= div_cnt + 1;
	end
endmodule

// *** sim/test_gmss_message_sweep_sync.sv ***
// Self-checking bench for the message and sweep block
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t mismatch", $time); end end
module test_gpib_message_sweep_sync
	import gmss_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, msg_byte_valid = 1'b0, msg_byte_last = 1'b0;
	logic serial_poll = 1'b0, backup_ok_pin = 1'b1, macro_store_done = 1'b0;
	logic talk_addressed = 1'b0, talk_pending = 1'b0;
	logic nrfd_q, busy_q, exec_cmd_valid_q, exec_done, sweep_div_pin, sweep_arm_q, srq_q;
	logic single_sweep_mode_q, sweep_running_q, partial_data_q, macro_valid_q, talk_valid_q;
	logic talk_enable_q, end_of_sweep_request_enable_q, msg_overflow_q;
	logic [7:0] msg_byte = 8'h00, exec_cmd_q, talk_data_q, last_cmd;
	logic [7:0] long_msg [$];
	int num_errors = 0, n_checks = 0, n_exec = 0, n_arm = 0, n_talk = 0, exec_div, div_cnt, k;
	// Token, expected issue, expected request enable
	logic [9:0] rows [4] = '{10'h004, 10'h110, 10'h203, 10'h3A5};
	gmss_core DUT (
		.clk(clk),
		.rst(rst),
		.msg_byte_valid(msg_byte_valid),
		.msg_byte(msg_byte),
		.msg_byte_last(msg_byte_last),
		.nrfd_q(nrfd_q),
		.busy_q(busy_q),
		.msg_overflow_q(msg_overflow_q),
		.exec_cmd_valid_q(exec_cmd_valid_q),
		.exec_cmd_q(exec_cmd_q),
		.exec_done(exec_done),
		.sweep_div_pin(sweep_div_pin),
		.backup_ok_pin(backup_ok_pin),
		.single_sweep_mode_q(single_sweep_mode_q),
		.sweep_arm_q(sweep_arm_q),
		.sweep_running_q(sweep_running_q),
		.partial_data_q(partial_data_q),
		.srq_q(srq_q),
		.serial_poll(serial_poll),
		.end_of_sweep_request_enable_q(end_of_sweep_request_enable_q),
		.macro_valid_q(macro_valid_q),
		.macro_store_done(macro_store_done),
		.talk_addressed(talk_addressed),
		.talk_pending(talk_pending),
		.talk_enable_q(talk_enable_q),
		.talk_valid_q(talk_valid_q),
		.talk_data_q(talk_data_q)
	);
	gmss_inst_model u_inst (
		.clk(clk),
		.exec_cmd_valid_q(exec_cmd_valid_q),
		.sweep_arm_q(sweep_arm_q),
		.sweep_running_q(sweep_running_q),
		.exec_done(exec_done),
		.sweep_div_pin(sweep_div_pin),
		.div_cnt(div_cnt)
	);
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (exec_cmd_valid_q === 1'b1) begin
			n_exec <= n_exec + 1;
			last_cmd <= exec_cmd_q;
			exec_div <= div_cnt;
		end
		n_arm <= n_arm + int'(sweep_arm_q === 1'b1);
		n_talk <= n_talk + int'(talk_valid_q === 1'b1);
	end
	task complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wait_idle;
		int n;
		for (n = 0; n < 600 && (nrfd_q !== 1'b0 || busy_q !== 1'b0); n++)
			@(negedge clk);
		if (n == 600) begin
			num_errors++;
			complete_run;
		end
	endtask
	task msg(input logic [7:0] t [$]);
		wait_idle;
		foreach (t[j]) begin
			msg_byte_valid = 1'b1;
			msg_byte = t[j];
			msg_byte_last = (j == t.size() - 1);
			@(negedge clk);
		end
		msg_byte_valid = 1'b0;
		msg_byte_last = 1'b0;
		@(negedge clk);
		wait_idle;
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		`CK(nrfd_q, 1'b0)
		foreach (rows[r]) begin
			k = n_exec;
			msg('{rows[r][7:0]});
			`CK(n_exec - k, int'(rows[r][8]))
			`CK(end_of_sweep_request_enable_q, rows[r][9])
			if (rows[r][8]) `CK(last_cmd, rows[r][7:0])
		end
		$display("rows done");
		// Second token and talk address offered while busy
		k = n_exec;
		msg_byte_valid = 1'b1;
		msg_byte = 8'h30;
		msg_byte_last = 1'b1;
		@(negedge clk);
		msg_byte = 8'h77;
		talk_addressed = 1'b1;
		repeat (5) @(negedge clk);
		`CK(n_talk, 0)
		`CK(talk_enable_q, 1'b0)
		msg_byte_valid = 1'b0;
		wait_idle;
		repeat (3) @(negedge clk);
		`CK(n_exec - k, 1)
		`CK(last_cmd, 8'h30)
		`CK(n_talk, 1)
		`CK(talk_data_q, IDLE_TALK_BYTE)
		`CK(talk_enable_q, 1'b1)
		talk_addressed = 1'b0;
		@(negedge clk);
		talk_pending = 1'b1;
		talk_addressed = 1'b1;
		repeat (3) @(negedge clk);
		`CK(n_talk, 1)
		`CK(talk_enable_q, 1'b1)
		talk_addressed = 1'b0;
		talk_pending = 1'b0;
		$display("refuse done");
		// Wait on a free-running sweep
		msg('{CMD_WAIT});
		`CK(partial_data_q, 1'b1)
		msg('{CMD_SINGLE_SWEEP_ARM});
		`CK(single_sweep_mode_q, 1'b1)
		`CK(n_arm, 0)
		// Let the leftover free-run sweep finish before arming
		for (k = 0; k < 400 && sweep_running_q !== 1'b0; k++)
			@(negedge clk);
		if (k == 400) begin
			num_errors++;
			complete_run;
		end
		msg('{CMD_SINGLE_SWEEP_ARM, CMD_WAIT, 8'h40});
		`CK(n_arm, 1)
		`CK(last_cmd, 8'h40)
		`CK(exec_div, int'(DIVS_PER_SWEEP))
		`CK(partial_data_q, 1'b0)
		`CK(srq_q, 1'b1)
		serial_poll = 1'b1;
		@(negedge clk);
		serial_poll = 1'b0;
		@(negedge clk);
		`CK(srq_q, 1'b0)
		$display("sweep done");
		macro_store_done = 1'b1;
		@(negedge clk);
		macro_store_done = 1'b0;
		@(negedge clk);
		`CK(macro_valid_q, 1'b1)
		backup_ok_pin = 1'b0;
		repeat (4) @(negedge clk);
		`CK(macro_valid_q, 1'b0)
		$display("macro done");
		repeat (BUF_DEPTH + 1) long_msg.push_back(CMD_END_REQ_ON);
		msg(long_msg);
		`CK(msg_overflow_q, 1'b1)
		msg('{CMD_END_REQ_ON});
		`CK(msg_overflow_q, 1'b0)
		$display("overflow done");
		complete_run;
	end
endmodule
